// ---- design/pas_pkg.sv ----
// Package: constants and configuration carrier for the analog output scaler
package pas_pkg;
    // APB register byte offsets
    localparam logic [7:0] PAS_CTRL = 8'h00;
    localparam logic [7:0] PAS_LIMIT = 8'h04;
    localparam logic [7:0] PAS_WIN = 8'h08;
    localparam logic [7:0] PAS_CORR = 8'h0C;
    localparam logic [7:0] PAS_UFS = 8'h10;
    localparam logic [7:0] PAS_DBAND = 8'h14;
    localparam logic [7:0] PAS_STAT = 8'h18;
    localparam logic [7:0] PAS_PRESS = 8'h1C;
    // Field positions
    localparam int CTRL_SCALE = 0;
    localparam int CTRL_REV = 1;
    localparam int CTRL_SETP = 2;
    localparam int CTRL_UNIT = 3;
    localparam int CTRL_STORE = 8;
    localparam int HI_LSB = 8;
    localparam int NEG_LSB = 8;
    localparam int OFS_LSB = 16;
    localparam int SP_BIT = 16;
    // Unit classes
    localparam logic [1:0] UNIT_ABS = 2'h0;
    localparam logic [1:0] UNIT_DIFF = 2'h2;
    // Limits and scaling figures
    localparam int PCT_FULL = 100;
    localparam int PCT_MAX = 99;
    localparam int CORR_LIM = 120;
    localparam int CORR_DIV = 20000;
    localparam int DAC_MAX = 4095;
    // Reset values
    localparam logic [6:0] RST_LOW = 7'h00;
    localparam logic [6:0] RST_HIGH = 7'h64;
    localparam logic [6:0] RST_WOFF = 7'h00;
    localparam logic [6:0] RST_WWID = 7'h00;
    localparam logic [19:0] RST_UFS = 20'h00000;
    localparam logic [7:0] RST_DB = 8'h00;

    typedef struct packed {
        logic scale_on;
        logic reverse;
        logic setpoint;
        logic [1:0] unit_sel;
        logic [6:0] low_pct;
        logic [6:0] high_pct;
        logic [6:0] win_off;
        logic [6:0] win_wid;
        logic signed [7:0] slope_pos;
        logic signed [7:0] slope_neg;
        logic signed [7:0] offs;
        logic [19:0] user_fs;
        logic [7:0] dband;
    } pas_cfg_t;
endpackage

// ---- design/pas_scaler.sv ----
// Pressure to DAC code scaler with APB configuration registers
`timescale 1ns/10ps
`default_nettype none

// Function
// [R1] Default scaling maps zero reading to code zero, full scale to top code.
// [R2] Low limit is integer percent of range, used when custom scaling is on.
// [R3] High limit is commanded percent of range, same one-percent steps.
// [R4] Reverse scaling gives high limit at window bottom, low limit at top.
// [R5] Window offset works identically in normal and reverse modes.
// [R6] Window offset accepts 0 to 99 percent, resets to zero.
// [R7] Pressure at window offset is the new minimum, giving lowest output.
// [R8] Window width 0 to 99 percent; zero means full 100 percent.
// [R9] Window spans linearly between low and high output limits.
// [R10] Positive slope applies to positive pressures and differential positive side.
// [R11] Negative slope applies only to differential negative side.
// [R12] User offset correction is added to the pressure curve.
// [R13] Slope and offset corrections are signed, limited to plus or minus 120.
// [R14] Corrected = reading*(1+m/20000) + b/20000*full scale.
// [R15] Correction follows the already compensated incoming reading.
// [R16] User full scale clamps to half..one factory scale; zero restores factory.
// [R17] User full scale is the reference for all range arithmetic.
// [R18] Store command snapshots settings; settings reload at power-up.
// [R19] Set-point mode: low limit below offset, high at or above.
// [R20] Offset is measured from range minimum, negative full scale if differential.
// [R21] Deadband: switch high at point plus band, low at point minus band.
// [R22] Host enables before changing parameters; reads need no enable. The scaler checks no enable: writes apply unless boot_load is high.
// [R23] Output clamps to limits for pressures outside the window.
module pas_scaler
    import pas_pkg::*;
#(
    parameter logic [19:0] FS_FACT = 20'h186A0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rd_valid,
    input wire logic signed [19:0] rd_press,
    input wire logic boot_load,
    input wire pas_cfg_t boot_cfg,
    output logic store_req,
    output pas_cfg_t store_cfg,
    output logic [11:0] dac_code,
    output logic dac_valid
);
    pas_cfg_t cfg_q;
    logic wr_en;
    logic sp_q;
    logic s1_v_q;
    logic signed [23:0] pc_q;
    logic [31:0] rdat;
    logic map_ok;

    // Saturate a signed correction byte to the legal band
    function automatic logic [7:0] sat120(input logic [7:0] v);
        logic signed [7:0] s;
        s = v;
        if (s > 8'sd120) begin
            sat120 = 8'h78;
        end else if (s < -8'sd120) begin
            sat120 = 8'h88;
        end else begin
            sat120 = v;
        end
    endfunction

    // Saturate a percent field to a maximum
    function automatic logic [6:0] satp(input logic [6:0] v, input int mx);
        satp = (int'(v) > mx) ? 7'(mx) : v;
    endfunction

    // Keep user full scale between half and one factory scale
    function automatic logic [19:0] satfs(input logic [19:0] v);
        if (v == 20'h00000) begin
            satfs = v;
        end else if (v > FS_FACT) begin
            satfs = FS_FACT;
        end else if (v < (FS_FACT >> 1)) begin
            satfs = FS_FACT >> 1;
        end else begin
            satfs = v;
        end
    endfunction

    assign wr_en = psel && penable && pwrite;
    // Zero wait states: reads are prepared in the setup cycle
    assign pready = 1'b1;

    // Configuration registers; boot reload wins over a bus write
    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg_q <= '0;
            cfg_q.low_pct <= RST_LOW;
            cfg_q.high_pct <= RST_HIGH; // R1
            cfg_q.win_off <= RST_WOFF; // R6
            cfg_q.win_wid <= RST_WWID; // R8
            cfg_q.user_fs <= RST_UFS;
            cfg_q.dband <= RST_DB;
        end else if (boot_load) begin
            cfg_q <= boot_cfg; // R18
        end else if (wr_en) begin
            case (paddr)
                PAS_CTRL: begin
                    cfg_q.scale_on <= pwdata[CTRL_SCALE];
                    cfg_q.reverse <= pwdata[CTRL_REV];
                    cfg_q.setpoint <= pwdata[CTRL_SETP];
                    cfg_q.unit_sel <= pwdata[CTRL_UNIT +: 2];
                end
                PAS_LIMIT: begin
                    cfg_q.low_pct <= satp(pwdata[6:0], PCT_FULL); // R2
                    cfg_q.high_pct <= satp(pwdata[HI_LSB +: 7], PCT_FULL); // R3
                end
                PAS_WIN: begin
                    cfg_q.win_off <= satp(pwdata[6:0], PCT_MAX); // R6
                    cfg_q.win_wid <= satp(pwdata[HI_LSB +: 7], PCT_MAX); // R8
                end
                PAS_CORR: begin
                    cfg_q.slope_pos <= sat120(pwdata[7:0]); // R13
                    cfg_q.slope_neg <= sat120(pwdata[NEG_LSB +: 8]); // R13
                    cfg_q.offs <= sat120(pwdata[OFS_LSB +: 8]); // R13
                end
                PAS_UFS: cfg_q.user_fs <= satfs(pwdata[19:0]); // R16
                PAS_DBAND: cfg_q.dband <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Store request: one-cycle pulse with a settings snapshot
    always_ff @(posedge mclk) begin
        if (reset) begin
            store_req <= 1'b0;
            store_cfg <= '0;
        end else begin
            store_req <= wr_en && paddr == PAS_CTRL && pwdata[CTRL_STORE]; // R18
            store_cfg <= cfg_q;
        end
    end

    // Read mux
    always_comb begin
        rdat = 32'h00000000;
        map_ok = 1'b1;
        case (paddr)
            PAS_CTRL: rdat[4:0] = {cfg_q.unit_sel, cfg_q.setpoint,
                                   cfg_q.reverse, cfg_q.scale_on};
            PAS_LIMIT: rdat[14:0] = {cfg_q.high_pct, 1'b0, cfg_q.low_pct};
            PAS_WIN: rdat[14:0] = {cfg_q.win_wid, 1'b0, cfg_q.win_off};
            PAS_CORR: rdat[23:0] = {cfg_q.offs, cfg_q.slope_neg, cfg_q.slope_pos};
            PAS_UFS: rdat[19:0] = cfg_q.user_fs;
            PAS_DBAND: rdat[7:0] = cfg_q.dband;
            PAS_STAT: rdat[16:0] = {sp_q, 4'h0, dac_code};
            PAS_PRESS: rdat = {{8{pc_q[23]}}, pc_q};
            default: map_ok = 1'b0;
        endcase
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rdat;
            pslverr <= !map_ok;
        end
    end

    // Reference full scale and range geometry
    logic signed [23:0] fsr;
    logic signed [23:0] span;
    logic signed [23:0] rmin;
    logic diff;
    always_comb begin
        diff = cfg_q.unit_sel == UNIT_DIFF;
        fsr = {4'h0, (cfg_q.user_fs == 20'h00000) ? FS_FACT : cfg_q.user_fs}; // R16 R17
        span = diff ? (fsr <<< 1) : fsr;
        rmin = diff ? -fsr : 24'sh000000; // R20
    end

    // Stage 1: user slope and offset on the compensated reading
    logic signed [7:0] slope;
    logic signed [47:0] corr;
    always_comb begin
        if (rd_press >= 0) begin
            slope = cfg_q.slope_pos; // R10
        end else if (diff) begin
            slope = cfg_q.slope_neg; // R11
        end else begin
            slope = 8'sh00; // Below zero on a one-sided unit: no slope
        end
        corr = 48'(rd_press) * 48'(CORR_DIV) + 48'(rd_press) * 48'(slope)
               + 48'(cfg_q.offs) * 48'(fsr); // R12 R14
        corr = corr / 48'(CORR_DIV); // R14
    end

    // Register the corrected reading; later stages only ever see compensated data
    always_ff @(posedge mclk) begin
        if (reset) begin
            s1_v_q <= 1'b0;
            pc_q <= 24'sh000000;
        end else begin
            s1_v_q <= rd_valid; // R15
            if (rd_valid) begin
                pc_q <= 24'(corr); // R15
            end
        end
    end

    // Stage 2: window, limits, reverse and set point
    logic signed [47:0] wlo;
    logic signed [47:0] wwid;
    logic signed [47:0] pos;
    logic signed [47:0] frac;
    logic signed [47:0] lo_c;
    logic signed [47:0] hi_c;
    logic signed [47:0] lin;
    logic signed [47:0] db;
    logic sp_d;
    always_comb begin
        wlo = 48'(rmin) + 48'(span) * 48'(cfg_q.win_off) / 48'(PCT_FULL); // R5 R7 R20
        if (cfg_q.win_wid == 7'h00) begin
            wwid = 48'(span); // R8
        end else begin
            wwid = 48'(span) * 48'(cfg_q.win_wid) / 48'(PCT_FULL); // R8
        end
        pos = 48'(pc_q) - wlo; // R7
        if (pos < 0) begin
            frac = 48'sd0; // R23
        end else if (pos >= wwid) begin
            frac = 48'(DAC_MAX); // R23
        end else begin
            frac = pos * 48'(DAC_MAX) / wwid; // R9
        end
        // Reverse only flips the curve, so the window itself is untouched
        if (cfg_q.reverse) begin
            frac = 48'(DAC_MAX) - frac; // R4 R5
        end
        if (cfg_q.scale_on) begin
            lo_c = 48'(cfg_q.low_pct) * 48'(DAC_MAX) / 48'(PCT_FULL); // R2
            hi_c = 48'(cfg_q.high_pct) * 48'(DAC_MAX) / 48'(PCT_FULL); // R3
        end else begin
            lo_c = 48'sd0; // R1
            hi_c = 48'(DAC_MAX); // R1
        end
        lin = lo_c + (hi_c - lo_c) * frac / 48'(DAC_MAX); // R9
        db = 48'(cfg_q.dband) * 48'(fsr) / 48'(CORR_DIV);
        sp_d = sp_q;
        if (48'(pc_q) >= wlo + db) begin
            sp_d = 1'b1; // R19 R21
        end else if (48'(pc_q) < wlo - db) begin
            sp_d = 1'b0; // R19 R21
        end
    end

    // Output code register; set point state moves only on new readings
    always_ff @(posedge mclk) begin
        if (reset) begin
            dac_code <= 12'h000;
            dac_valid <= 1'b0;
            sp_q <= 1'b0;
        end else begin
            dac_valid <= s1_v_q;
            if (s1_v_q) begin
                sp_q <= sp_d;
                if (cfg_q.setpoint) begin
                    dac_code <= 12'(sp_d ? hi_c : lo_c); // R19
                end else begin
                    dac_code <= 12'(lin); // R9
                end
            end
        end
    end

    // Checks run on the system clock and sleep through reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Steps: a store write, and readings below, above, at the bottom or in the band
    sequence s_store_wr;
        wr_en && paddr == PAS_CTRL && pwdata[CTRL_STORE] && !boot_load;
    endsequence
    sequence s_below;
        s1_v_q && !cfg_q.setpoint && pos < 0;
    endsequence
    sequence s_above;
        s1_v_q && !cfg_q.setpoint && pos >= wwid;
    endsequence
    sequence s_bottom;
        s1_v_q && !cfg_q.setpoint && !cfg_q.reverse && pos == 48'sd0;
    endsequence
    sequence s_rev_bottom;
        s1_v_q && !cfg_q.setpoint && cfg_q.reverse && pos == 48'sd0;
    endsequence
    sequence s_in_band;
        s1_v_q && cfg_q.setpoint && 48'(pc_q) < wlo + db && 48'(pc_q) >= wlo - db;
    endsequence
    // Factory curve: no custom limits and no reversal
    sequence s_factory;
        !cfg_q.scale_on && !cfg_q.reverse;
    endsequence

    // Store pulse and reading pipeline
    AST_STORE: assert property (s_store_wr |=> store_req ##1 !store_req) // R18
        else $error("store pulse wrong");
    AST_PIPE: assert property (rd_valid |=> s1_v_q ##1 dac_valid) // R15
        else $error("reading latency wrong");
    // Code stands between readings, so the converter never sees a glitch
    AST_HOLD: assert property (!s1_v_q |=> $stable(dac_code) && !dac_valid) // R9
        else $error("output code moved without a reading");
    // Correction result lands one edge after the reading
    AST_PRESS: assert property (rd_valid |=> pc_q == 24'($past(corr))) // R14
        else $error("corrected pressure wrong");

    // Clamping outside the window; reverse swaps the two ends
    AST_CLAMP_LO: assert property (s_below |=> dac_code == // R23
        ($past(cfg_q.reverse) ? 12'($past(hi_c)) : 12'($past(lo_c))))
        else $error("below window not clamped");
    AST_CLAMP_HI: assert property (s_above |=> dac_code == // R4
        ($past(cfg_q.reverse) ? 12'($past(lo_c)) : 12'($past(hi_c))))
        else $error("above window not clamped");

    // Window bottom gives the low limit, or the high one in reverse
    AST_BOTTOM: assert property (s_bottom |=> dac_code == 12'($past(lo_c))) // R7
        else $error("window bottom not at low limit");
    AST_REV_BOTTOM: assert property (s_rev_bottom // R4
        |=> dac_code == 12'($past(hi_c)))
        else $error("reverse window bottom not at high limit");

    // Factory curve runs from code zero to the top code
    AST_DEFAULT: assert property ((s_above and s_factory) |=> dac_code == 12'hFFF) // R1
        else $error("default top code wrong");
    AST_DEF_ZERO: assert property ((s_below and s_factory) |=> dac_code == 12'h000) // R1
        else $error("default zero code wrong");

    // Set point switching; inside the band the state holds
    AST_SETP_LO: assert property (s1_v_q && cfg_q.setpoint && 48'(pc_q) < wlo - db // R21
        |=> !sp_q && dac_code == 12'($past(lo_c)))
        else $error("set point not low");
    AST_SETP_HI: assert property (s1_v_q && cfg_q.setpoint && 48'(pc_q) >= wlo + db // R19
        |=> sp_q && dac_code == 12'($past(hi_c)))
        else $error("set point not high");
    AST_SETP_HOLD: assert property (s_in_band |=> sp_q == $past(sp_q)) // R21
        else $error("set point moved inside the band");

    // Stored fields stay in band; boot data is not clamped, so the cycle
    // right after a reload is left out
    AST_CORR_LIM: assert property ($past(boot_load) || // R13
        $signed(cfg_q.slope_pos) <= 8'sh78 && $signed(cfg_q.slope_pos) >= -8'sh78
        && $signed(cfg_q.slope_neg) <= 8'sh78 && $signed(cfg_q.slope_neg) >= -8'sh78
        && $signed(cfg_q.offs) <= 8'sh78 && $signed(cfg_q.offs) >= -8'sh78)
        else $error("correction out of band");
    AST_WIN_LIM: assert property (!$past(boot_load) |-> cfg_q.win_off <= 7'd99 // R6
        && cfg_q.win_wid <= 7'd99)
        else $error("window field out of band");
    AST_PCT_LIM: assert property (!$past(boot_load) |-> cfg_q.low_pct <= 7'h64 // R2 R3
        && cfg_q.high_pct <= 7'h64)
        else $error("output limit out of band");
    AST_UFS_LIM: assert property (!$past(boot_load) |-> cfg_q.user_fs == 20'h00000 // R16
        || cfg_q.user_fs <= FS_FACT && cfg_q.user_fs >= (FS_FACT >> 1))
        else $error("user full scale out of band");

    // Boot reload copies the saved settings whole
    AST_BOOT: assert property (boot_load |=> cfg_q == $past(boot_cfg)) // R18
        else $error("boot settings not loaded");
endmodule

`default_nettype wire

// ---- tb/pas_nvm_model.sv ----
// Nonvolatile settings store on the far side of the scaler
`timescale 1ns/10ps
`default_nettype none
module pas_nvm_model
    import pas_pkg::*;
(
    input wire logic mclk,
    input wire logic store_req,
    input wire pas_cfg_t store_cfg,
    input wire logic load_go,
    output logic boot_load,
    output pas_cfg_t boot_cfg
);
    pas_cfg_t saved_q;
    // Snapshot on store, replay on load; garbage between loads on purpose
    always_ff @(posedge mclk) begin
        if (store_req) begin
            saved_q <= store_cfg;
        end
        boot_load <= load_go;
        boot_cfg <= load_go ? saved_q : ~saved_q;
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the pressure analog output scaler
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import pas_pkg::*;
    localparam int FS = 100000;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, rd_valid;
    logic boot_load, store_req, dac_valid, load_go, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv, seed;
    logic signed [19:0] rd_press;
    pas_cfg_t boot_cfg, store_cfg;
    logic [11:0] dac_code;
    int bad_count, n_checks, e, p;
    int expq[$];

    pas_scaler #(.FS_FACT(20'h186A0)) pas_scaler_inst (.mclk(mclk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rd_valid(rd_valid),
        .rd_press(rd_press), .boot_load(boot_load), .boot_cfg(boot_cfg),
        .store_req(store_req), .store_cfg(store_cfg), .dac_code(dac_code),
        .dac_valid(dac_valid));
    pas_nvm_model pas_nvm_model_inst (.mclk(mclk), .store_req(store_req),
        .store_cfg(store_cfg), .load_go(load_go), .boot_load(boot_load),
        .boot_cfg(boot_cfg));

    // Free-running system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_checks++;
        if (g !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, g);
        end
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 100) begin
            n++;
            @(posedge mclk);
        end
        // A slave that never answers counts as a mismatch
        if (n >= 100) begin
            bad_count++;
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Host writes stand for commands already preceded by the enable
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(nm, ex, rv);
    endtask

    // Readings go back to back; the expected code is noted for the monitor
    task automatic rdg(input int pr, input int ex);
        @(posedge mclk);
        rd_valid <= 1'b1;
        rd_press <= 20'(pr);
        expq.push_back(ex);
    endtask

    task automatic flush();
        @(posedge mclk);
        rd_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Monitor pairs each new code with the oldest note
    always @(posedge mclk) begin
        if (dac_valid === 1'b1) begin
            if (expq.size() == 0) begin
                chk("dac_extra", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                chk("dac_code", 32'(e), {20'h0, dac_code});
            end
        end
    end

    // Watchdog, well beyond the couple of hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, rd_valid, load_go} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        rd_press = 20'h00000;
        reset = 1'b1;
        seed = 32'h5CE26C2C;
        bad_count = 0;
        n_checks = 0;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        rdc("limit", PAS_LIMIT, 32'h6400);
        rdc("win", PAS_WIN, 32'h0);
        rdc("unmapped", 8'h40, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        // Factory scaling, then random readings every cycle
        rdg(0, 0);
        rdg(FS, 4095);
        rdg(50000, 2047);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            p = int'(seed % 32'd100001);
            rdg(p, p * 4095 / FS);
        end
        flush();
        // Custom limits 20..97 percent, window 60 plus 20
        wr(PAS_CTRL, 32'h1);
        wr(PAS_LIMIT, 32'h6114);
        wr(PAS_WIN, 32'h143C);
        rdg(60000, 819);
        rdg(64000, 1449);
        rdg(80000, 3972);
        rdg(10000, 819);
        rdg(90000, 3972);
        flush();
        wr(PAS_CTRL, 32'h3);
        rdg(64000, 3341);
        rdg(60000, 3972);
        flush();
        // Set point 60 percent with 300-count band; middle holds
        wr(PAS_DBAND, 32'h3C);
        wr(PAS_CTRL, 32'h5);
        rdg(59000, 819);
        rdg(60299, 819);
        rdg(60300, 3972);
        rdg(59701, 3972);
        rdg(59699, 819);
        flush();
        rdc("stat", PAS_STAT, 32'h333);
        // Store, spoil, reload
        wr(PAS_CTRL, 32'h105);
        @(posedge mclk);
        chk("store_req", 32'h1, {31'h0, store_req});
        rdc("ctrl", PAS_CTRL, 32'h5);
        wr(PAS_WIN, 32'h0);
        load_go <= 1'b1;
        @(posedge mclk);
        load_go <= 1'b0;
        rdc("win_boot", PAS_WIN, 32'h143C);
        // Corrections, saturated slope and negative offset
        wr(PAS_CTRL, 32'h0);
        wr(PAS_WIN, 32'h0);
        wr(PAS_CORR, 32'h00D8007F);
        rdc("corr", PAS_CORR, 32'h00D80078);
        rdg(50000, 2051);
        flush();
        rdc("press", PAS_PRESS, 32'd50100);
        rdg(-10000, 0);
        flush();
        rdc("press_neg", PAS_PRESS, 32'hFFFFD828);
        wr(PAS_CORR, 32'h00009C00);
        wr(PAS_CTRL, 32'h10);
        rdg(-50000, 1028);
        flush();
        rdc("press_diff", PAS_PRESS, 32'hFFFF3DAA);
        // Reduced full scale clamps to half and becomes the reference
        wr(PAS_CTRL, 32'h0);
        wr(PAS_CORR, 32'h0);
        wr(PAS_UFS, 32'h7530);
        rdc("ufs", PAS_UFS, 32'hC350);
        rdg(25000, 2047);
        flush();
        wr(PAS_UFS, 32'h0);
        rdc("ufs_off", PAS_UFS, 32'h0);
        chk("pending", 32'h0, 32'(expq.size()));
        end_sim();
    end
endmodule
`default_nettype wire
